/* File: fade_timer.sv */
// fade sequencer: hold-off, ramp-down and ramp-up timing and dac stepping
`timescale 1ns/10ps
`default_nettype none
module fade_timer
    import led_port_pkg::*;
#(
    parameter int BASE_TICKS = FADE_BASE_TICK
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       pwm_tick,
    input  wire logic       run,
    input  wire logic       ramp_up_en,
    input  wire logic [2:0] hold_code,
    input  wire logic [2:0] down_code,
    input  wire logic [2:0] up_code,
    output logic [2:0]      dac,
    output logic            sinks_on,
    output fade_stat_s      stat
);
    typedef enum {ST_OFF, ST_HOLD, ST_DOWN, ST_UP, ST_ON} fade_e;
    fade_e      state;
    logic [22:0] cnt;
    logic [22:0] step_len;
    logic [22:0] hold_len;
    logic        run_q;

    // one dac step lasts an eighth of the selected ramp time
    function automatic logic [22:0] dur(input logic [2:0] code);
        logic [22:0] base;
        base = 23'(BASE_TICKS);
        dur = (code == 3'd0) ? 23'd0 : (base << (code - 3'd1));
    endfunction

    always_comb begin
        hold_len = dur(hold_code);
        step_len = (state == ST_UP) ? (dur(up_code) >> 3)
                                    : (dur(down_code) >> 3);
    end

    // the sequence is paced by the pwm clock only, so it runs even with no
    // port in pwm mode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_OFF;
            cnt   <= '0;
            dac   <= '0;
            run_q <= 1'b0;
        end else begin
            run_q <= run;
            case (state)
                ST_OFF: begin
                    if (run && !run_q) begin
                        cnt <= '0;
                        if (ramp_up_en && up_code != 3'd0) begin
                            dac   <= '0;
                            state <= ST_UP;
                        end else begin
                            dac   <= DAC_FULL;
                            state <= ST_ON;
                        end
                    end
                end
                ST_ON: begin
                    if (!run) begin
                        cnt   <= '0;
                        dac   <= DAC_FULL;
                        state <= (hold_code != 3'd0) ? ST_HOLD : ST_DOWN;
                        if (hold_code == 3'd0 && down_code == 3'd0) begin
                            dac   <= '0;
                            state <= ST_OFF;
                        end
                    end
                end
                ST_HOLD: begin
                    if (run) begin
                        state <= ST_ON;
                    end else if (pwm_tick) begin
                        cnt <= cnt + 23'd1;
                        if (cnt + 23'd1 >= hold_len) begin
                            cnt <= '0;
                            if (down_code == 3'd0) begin
                                dac   <= '0;
                                state <= ST_OFF;
                            end else begin
                                state <= ST_DOWN;
                            end
                        end
                    end
                end
                ST_DOWN: begin
                    if (run) begin
                        state <= ST_UP;
                        cnt   <= '0;
                    end else if (down_code == 3'd0) begin
                        dac   <= '0;
                        state <= ST_OFF;
                    end else if (pwm_tick) begin
                        cnt <= cnt + 23'd1;
                        if (cnt + 23'd1 >= step_len) begin
                            cnt <= '0;
                            if (dac == 3'd0) begin
                                state <= ST_OFF;
                            end else begin
                                dac <= dac - 3'd1;
                            end
                        end
                    end
                end
                ST_UP: begin
                    if (!run) begin
                        state <= ST_DOWN;
                        cnt   <= '0;
                    end else if (up_code == 3'd0) begin
                        dac   <= DAC_FULL;
                        state <= ST_ON;
                    end else if (pwm_tick) begin
                        cnt <= cnt + 23'd1;
                        if (cnt + 23'd1 >= step_len) begin
                            cnt <= '0;
                            if (dac == DAC_FULL) begin
                                state <= ST_ON;
                            end else begin
                                dac <= dac + 3'd1;
                            end
                        end
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    assign sinks_on  = (state != ST_OFF);
    assign stat.hold = (state == ST_HOLD);
    assign stat.down = (state == ST_DOWN);
    assign stat.up   = (state == ST_UP);
endmodule
`default_nettype wire

/* File: led_port_ctrl.sv */
// five-port led/gpio control: mode registers, shutdown, standby and fading
//
// Contract
// - input-level read shows pin level for input ports, zero otherwise
// - input-level register is read-only; writes are dropped
// - standby when every mode is 0x00, 0x01 or 0xff; mirror off
// - mode 0x02..0xfe enables that port's own gated mirror
// - pwm port mirror enabled only during on-time
// - shutdown turns sink ports off hi-z; logic ports keep working
// - run bit d0 of config 0x10 clear enters shutdown, set leaves
// - registers stay accessible and unchanged across shutdown
// - logic-to-sink rewrite in shutdown goes off at once, starts later
// - sink-to-logic rewrite in shutdown drives logic level at once
// - shutdown holds full current for hold-off, then ramps down
// - hold-off code 0 none, 1..7 from 0.0655 s doubling to 4.194 s
// - ramp-down code 0 immediate, 1..7 from 0.0655 s doubling
// - ramp-up code 0 immediate, 1..7 from 0.0655 s doubling
// - config reports hold, down, up status and holds ramp-up enable
// - one write clearing run starts shutdown with its fade sequence
// - fades count pwm-clock periods; timebase runs during any fade
// - 3-bit dac scales the shared current reference for all sinks
// - boost ignores dac, off after ramp-down, fully on at ramp-up
// - global current caps the dac on both ramps
// - timebase is 31.25 khz and a pwm period is 256 cycles
// - mode codes: low, high/input, static, pwm n/256, hi-z default
`timescale 1ns/10ps
`default_nettype none
module led_port_ctrl
    import led_port_pkg::*;
#(
    parameter int PORTS      = NUM_PORTS,
    parameter int FADE_TICKS = FADE_BASE_TICK,
    parameter int CLK_DIV    = PWM_DIV
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire reg_req_s         reg_req,
    output logic [7:0]            reg_rdata,
    input  wire logic [PORTS-1:0] pin_in,
    output logic [PORTS-1:0]      pin_out,
    output logic [PORTS-1:0]      pin_oe,
    output logic [PORTS-1:0]      mirror_en,
    output logic [2:0]            current_ref,
    output logic                  boost_en,
    output logic                  standby
);
    // =========================================================
    // registers
    logic [7:0]       port_mode [PORTS];
    logic [7:0]       config_reg;
    logic [7:0]       fade_down_timing;
    logic [7:0]       fade_up_timing;
    logic [2:0]       global_current;
    logic [PORTS-1:0] pin_meta;
    logic [PORTS-1:0] pin_sync;
    fade_stat_s       stat;
    logic [2:0]       dac;
    logic             sinks_on;

    // mode writes take effect at once, whatever the run state
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_mode
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    port_mode[g] <= RST_PORT_MODE;
                end else if (reg_req.wr &&
                    reg_req.addr == ADDR_PORT_MODE_BASE + 8'(g)) begin
                    port_mode[g] <= reg_req.wdata;
                end
            end
        end
    endgenerate

    // status bits are live state, never stored, so writes cannot clobber them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            config_reg <= RST_CONFIG;
        end else if (reg_req.wr && reg_req.addr == ADDR_CONFIG) begin
            config_reg <= reg_req.wdata & CFG_WRITE_MASK;
        end
    end

    // timing bytes are kept whole; the sequencer decodes only its fields
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fade_down_timing <= RST_FADE;
        end else if (reg_req.wr && reg_req.addr == ADDR_FADE_DOWN) begin
            fade_down_timing <= reg_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fade_up_timing <= RST_FADE;
        end else if (reg_req.wr && reg_req.addr == ADDR_FADE_UP) begin
            fade_up_timing <= reg_req.wdata;
        end
    end

    // only the low three bits hold a code; the rest read back as zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            global_current <= RST_GLOBAL;
        end else if (reg_req.wr && reg_req.addr == ADDR_GLOBAL_CURRENT) begin
            global_current <= reg_req.wdata[2:0];
        end
    end

    // =========================================================
    // pin input synchroniser
    // pins move at any moment: two flops before any logic reads them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // =========================================================
    // pwm timebase
    logic [15:0] div_cnt;
    logic        pwm_tick;
    logic [7:0]  pwm_phase;

    // divider runs always, so the timebase never stalls mid-fade
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_cnt <= '0;
        end else if (div_cnt == 16'(CLK_DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 16'd1;
        end
    end
    assign pwm_tick = (div_cnt == 16'(CLK_DIV - 1));

    // the phase wraps after 256 ticks, one full pwm period
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwm_phase <= '0;
        end else if (pwm_tick) begin
            pwm_phase <= pwm_phase + 8'd1;
        end
    end

    // =========================================================
    // fade sequencer
    fade_timer #(
        .BASE_TICKS (FADE_TICKS)
    ) u_fade (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .pwm_tick   (pwm_tick),
        .run        (config_reg[CFG_RUN_BIT]),
        .ramp_up_en (config_reg[CFG_RAMP_UP_EN_BIT]),
        .hold_code  (fade_down_timing[HOLD_LSB +: 3]),
        .down_code  (fade_down_timing[RAMP_LSB +: 3]),
        .up_code    (fade_up_timing[RAMP_LSB +: 3]),
        .dac        (dac),
        .sinks_on   (sinks_on),
        .stat       (stat)
    );

    // =========================================================
    // port outputs
    logic [PORTS-1:0] is_sink;
    logic [PORTS-1:0] is_input;
    logic [PORTS-1:0] sink_on_now;
    logic [PORTS-1:0] next_out;
    logic [PORTS-1:0] next_oe;
    logic [PORTS-1:0] next_mirror;

    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            always_comb begin
                is_sink[g]     = 1'b1;
                is_input[g]    = 1'b0;
                sink_on_now[g] = pwm_phase < port_mode[g];
                case (port_mode[g])
                    MODE_LOW, MODE_HIZ: begin
                        is_sink[g] = 1'b0;
                    end
                    MODE_HIGH: begin
                        is_sink[g]  = 1'b0;
                        is_input[g] = 1'b1;
                    end
                    // a static sink conducts through the whole pwm period
                    MODE_STATIC: begin
                        sink_on_now[g] = 1'b1;
                    end
                    default: ;
                endcase
                // open drain: logic low pulls down, logic high releases
                next_oe[g]  = (port_mode[g] == MODE_LOW) ||
                              (is_sink[g] && sinks_on && sink_on_now[g]);
                next_out[g] = 1'b0;
                // sinks go hi-z the moment shutdown completes
                next_mirror[g] = is_sink[g] && sinks_on &&
                                 sink_on_now[g];
            end
        end
    endgenerate

    // ports are open drain: pin_out stays low and pin_oe does the driving
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_out <= '0;
        end else begin
            pin_out <= next_out;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_oe <= '0;
        end else begin
            pin_oe <= next_oe;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mirror_en <= '0;
        end else begin
            mirror_en <= next_mirror;
        end
    end

    // =========================================================
    // current reference and boost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            current_ref <= '0;
        end else begin
            // dac capped by global current: lower of the two
            current_ref <= (dac < global_current) ? dac
                                                  : global_current;
        end
    end

    // boost ignores the dac: fully on in every sequencer state but off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            boost_en <= 1'b0;
        end else begin
            boost_en <= sinks_on;
        end
    end

    // standby follows mode values only, so shutdown leaves it alone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            standby <= 1'b1;
        end else begin
            standby <= ~|is_sink;
        end
    end

    // =========================================================
    // read path
    always_comb begin
        reg_rdata = 8'h00;
        case (reg_req.addr)
            // pin levels only: nothing is stored here, so writes are lost
            ADDR_INPUT_LEVELS: begin
                reg_rdata = 8'({pin_sync & is_input});
            end
            // status bits come live from the sequencer
            ADDR_CONFIG: begin
                reg_rdata = config_reg;
                reg_rdata[CFG_HOLD_STAT_BIT] = stat.hold;
                reg_rdata[CFG_DOWN_STAT_BIT] = stat.down;
                reg_rdata[CFG_UP_STAT_BIT]   = stat.up;
            end
            ADDR_FADE_DOWN: begin
                reg_rdata = fade_down_timing;
            end
            ADDR_FADE_UP: begin
                reg_rdata = fade_up_timing;
            end
            ADDR_GLOBAL_CURRENT: begin
                reg_rdata = {5'h00, global_current};
            end
            // mode registers sit at consecutive addresses from the base
            default: begin
                for (int i = 0; i < PORTS; i++) begin
                    if (reg_req.addr == ADDR_PORT_MODE_BASE + 8'(i)) begin
                        reg_rdata = port_mode[i];
                    end
                end
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: led_port_ctrl_assertions.sv */
// concurrent checks on the port-level behaviour of led_port_ctrl
`timescale 1ns/10ps
`default_nettype none
module led_port_ctrl_assertions
    import led_port_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic             sys_clk,
    input wire logic             srst,
    input wire reg_req_s         reg_req,
    input wire logic [7:0]       reg_rdata,
    input wire logic [PORTS-1:0] pin_in,
    input wire logic [PORTS-1:0] pin_out,
    input wire logic [PORTS-1:0] pin_oe,
    input wire logic [PORTS-1:0] mirror_en,
    input wire logic [2:0]       current_ref,
    input wire logic             boost_en,
    input wire logic             standby
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // assertions
    chk_reset_quiet: assert property ($fell(srst) |->
        pin_oe == '0 && mirror_en == '0 && current_ref == 3'h0 &&
        !boost_en && standby)
        else $error("outputs not quiet after reset");
    chk_standby_mirror: assert property (
        standby |-> mirror_en == '0)
        else $error("mirror enabled in standby");
    chk_open_drain: assert property (pin_out == '0)
        else $error("pin driven high");
    chk_mirror_pulls: assert property (
        (pin_oe & mirror_en) == mirror_en)
        else $error("mirror on without pin pull");
    chk_off_dark: assert property (
        (!boost_en)[*2] |-> mirror_en == '0)
        else $error("mirror on while shut down");
    chk_off_ref: assert property (
        (!boost_en)[*2] |-> current_ref == 3'h0)
        else $error("current reference up while boost off");
    chk_levels_zero: assert property (
        reg_req.addr == ADDR_INPUT_LEVELS |-> reg_rdata[7:5] == 3'b000)
        else $error("reserved input level bits set");
    chk_up_write: assert property (
        reg_req.wr && reg_req.addr == ADDR_FADE_UP ##1
        reg_req.addr == ADDR_FADE_UP |-> reg_rdata == $past(reg_req.wdata))
        else $error("ramp-up timing write lost");
    cover property ($rose(boost_en));
    cover property ($fell(boost_en));
    cover property (current_ref == DAC_FULL);
    cover property ($fell(standby));
endmodule
`default_nettype wire

/* File: led_port_pkg.sv */
// shared constants and types for the led port shutdown and fade block
package led_port_pkg;
    localparam int NUM_PORTS = 5;

    // register addresses as seen from the serial slave
    localparam logic [7:0] ADDR_PORT_MODE_BASE = 8'h00;
    localparam logic [7:0] ADDR_INPUT_LEVELS   = 8'h0e;
    localparam logic [7:0] ADDR_CONFIG         = 8'h10;
    localparam logic [7:0] ADDR_FADE_DOWN      = 8'h11;
    localparam logic [7:0] ADDR_FADE_UP        = 8'h12;
    localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h15;

    // configuration register fields
    localparam int CFG_RUN_BIT        = 0;
    localparam int CFG_RESET_RUN_BIT  = 1;
    localparam int CFG_RAMP_UP_EN_BIT = 2;
    localparam int CFG_HOLD_STAT_BIT  = 3;
    localparam int CFG_DOWN_STAT_BIT  = 4;
    localparam int CFG_UP_STAT_BIT    = 5;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hc7;

    // fade timing fields
    localparam int HOLD_LSB = 3;
    localparam int RAMP_LSB = 0;

    // port mode encodings
    localparam logic [7:0] MODE_LOW    = 8'h00;
    localparam logic [7:0] MODE_HIGH   = 8'h01;
    localparam logic [7:0] MODE_STATIC = 8'h02;
    localparam logic [7:0] MODE_HIZ    = 8'hff;

    // reset values
    localparam logic [7:0] RST_PORT_MODE = 8'hff;
    localparam logic [7:0] RST_CONFIG    = 8'h00;
    localparam logic [7:0] RST_FADE      = 8'h00;
    localparam logic [2:0] RST_GLOBAL    = 3'h7;
    localparam logic [2:0] DAC_FULL      = 3'h7;

    // timebase: 31.25 kHz pwm clock from the 100 MHz system clock
    localparam int SYS_CLK_HZ     = 100_000_000;
    localparam int PWM_CLK_HZ     = 31_250;
    localparam int PWM_DIV        = SYS_CLK_HZ / PWM_CLK_HZ;
    localparam int PWM_PERIOD     = 256;
    localparam int FADE_BASE_TICK = 2048;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic hold;
        logic down;
        logic up;
    } fade_stat_s;
endpackage

/* File: test_led_port_ctrl.sv */
// self-checking testbench for led_port_ctrl
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_led_port_ctrl;
    import led_port_pkg::*;
    // short timebase keeps fades to tens of cycles
    localparam int DIV = 2;
    localparam int FT  = 16;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    reg_req_s   req = '0;
    logic [7:0] reg_rdata;
    logic [4:0] pin_in = 5'h00;
    logic [4:0] pin_out, pin_oe, mirror_en;
    logic [2:0] current_ref;
    logic       boost_en, standby;
    int         err_total = 0;
    int         check_count = 0;
    int         cyc = 0;
    always #5 sys_clk = ~sys_clk;
    led_port_ctrl #(.PORTS(5), .FADE_TICKS(FT), .CLK_DIV(DIV)) uut (
        .sys_clk(sys_clk), .srst(srst), .reg_req(req), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .mirror_en(mirror_en), .current_ref(current_ref),
        .boost_en(boost_en), .standby(standby));
    // ==========================================================
    // bus and timing helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        #1 d = reg_rdata;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(ADDR_PORT_MODE_BASE + 8'(i), d);
            `CHK("port mode", RST_PORT_MODE, d)
        end
        rd(ADDR_CONFIG, d);
        `CHK("config", RST_CONFIG, d)
        rd(ADDR_FADE_DOWN, d);
        `CHK("fade down", RST_FADE, d)
        rd(ADDR_FADE_UP, d);
        `CHK("fade up", RST_FADE, d)
        `CHK("standby", 1'b1, standby)
        $display("test reset done");
    endtask
    task automatic t_inputs;
        logic [7:0] d;
        wr(ADDR_PORT_MODE_BASE, MODE_HIGH);
        wr(ADDR_PORT_MODE_BASE + 8'h02, MODE_HIGH);
        @(posedge sys_clk);
        pin_in <= 5'h15;
        cycles(5);
        rd(ADDR_INPUT_LEVELS, d);
        `CHK("input levels", 8'h05, d)
        wr(ADDR_INPUT_LEVELS, 8'hff);
        rd(ADDR_INPUT_LEVELS, d);
        `CHK("levels after write", 8'h05, d)
        `CHK("standby inputs", 1'b1, standby)
        $display("test inputs done");
    endtask
    task automatic t_standby;
        wr(ADDR_PORT_MODE_BASE + 8'h01, MODE_STATIC);
        cycles(3);
        `CHK("standby sink", 1'b0, standby)
        `CHK("mirror in shutdown", 5'h00, mirror_en)
        wr(ADDR_PORT_MODE_BASE + 8'h01, MODE_LOW);
        cycles(3);
        `CHK("standby low", 1'b1, standby)
        `CHK("low pulls", 1'b1, pin_oe[1])
        $display("test standby done");
    endtask
    task automatic t_fade;
        logic [7:0] d;
        logic [7:0] seen;
        int         n;
        int         hi;
        wr(ADDR_FADE_DOWN, 8'h09);
        wr(ADDR_FADE_UP, 8'h01);
        wr(ADDR_PORT_MODE_BASE + 8'h03, MODE_STATIC);
        wr(ADDR_CONFIG, 8'h05);
        seen = 8'h00;
        for (n = 0; n < 300 && current_ref !== DAC_FULL; n++) begin
            rd(ADDR_CONFIG, d);
            seen = seen | d;
        end
        `CHK("up status seen", 1'b1, seen[CFG_UP_STAT_BIT])
        `CHK("boost on", 1'b1, boost_en)
        cycles(3);
        `CHK("static mirror", 1'b1, mirror_en[3])
        wr(ADDR_PORT_MODE_BASE + 8'h04, 8'h80);
        cycles(4 * DIV * PWM_PERIOD);
        hi = 0;
        for (int i = 0; i < 2 * DIV * PWM_PERIOD; i++) begin
            cycles(1);
            hi += int'(mirror_en[4] === 1'b1);
        end
        `CHK("pwm on time", 1'b1, hi >= 500 && hi <= 524)
        wr(ADDR_CONFIG, 8'h04);
        seen = 8'h00;
        for (n = 0; n < 200 && current_ref === DAC_FULL; n++) begin
            rd(ADDR_CONFIG, d);
            seen = seen | d;
        end
        `CHK("hold status", 1'b1, seen[CFG_HOLD_STAT_BIT])
        `CHK("hold length", 1'b1, n >= FT*DIV - 4 && n <= FT*DIV + 8)
        for (n = 0; n < 300 && boost_en === 1'b1; n++) begin
            rd(ADDR_CONFIG, d);
            seen = seen | d;
        end
        `CHK("down status", 1'b1, seen[CFG_DOWN_STAT_BIT])
        `CHK("boost off", 1'b0, boost_en)
        cycles(3);
        `CHK("mirror off", 5'h00, mirror_en)
        rd(ADDR_FADE_DOWN, d);
        `CHK("fade down kept", 8'h09, d)
        rd(ADDR_PORT_MODE_BASE + 8'h03, d);
        `CHK("mode kept", MODE_STATIC, d)
        wr(ADDR_GLOBAL_CURRENT, 8'h03);
        wr(ADDR_FADE_UP, 8'h00);
        wr(ADDR_FADE_DOWN, 8'h00);
        wr(ADDR_CONFIG, 8'h05);
        cycles(10);
        `CHK("capped ref", 3'h3, current_ref)
        wr(ADDR_CONFIG, 8'h00);
        cycles(10);
        `CHK("quick off", 1'b0, boost_en)
        $display("test fade done");
    endtask
    task automatic t_shut_gpio;
        wr(ADDR_PORT_MODE_BASE, MODE_LOW);
        cycles(3);
        `CHK("logic low kept", 1'b1, pin_oe[0])
        `CHK("sink released", 1'b0, pin_oe[3])
        wr(ADDR_PORT_MODE_BASE + 8'h03, MODE_LOW);
        cycles(3);
        `CHK("sink to low", 1'b1, pin_oe[3])
        wr(ADDR_PORT_MODE_BASE, MODE_STATIC);
        cycles(3);
        `CHK("low to sink", 1'b0, pin_oe[0])
        wr(ADDR_CONFIG, 8'h01);
        cycles(4);
        `CHK("sink starts", 1'b1, pin_oe[0])
        `CHK("logic kept on run", 1'b1, pin_oe[3])
        `CHK("open drain", 5'h00, pin_out)
        $display("test shutdown gpio done");
    endtask
    // ==========================================================
    // sequence and hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset;
        t_inputs;
        t_standby;
        t_fade;
        t_shut_gpio;
        final_report;
    end
endmodule
bind led_port_ctrl led_port_ctrl_assertions #(.PORTS(PORTS)) chk (
    .sys_clk(sys_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mirror_en(mirror_en), .current_ref(current_ref), .boost_en(boost_en),
    .standby(standby));
`default_nettype wire
